// [psc_pkg.sv]
package psc_pkg;
	localparam int PSC_AW = 22;
	localparam int PSC_DW = 16;
	localparam int PSC_PAGE_WORDS = 8;
	localparam int PSC_PAGE_BITS = 3;
	localparam int PSC_CLK_NS = 10;
	// Times in their natural units, before conversion to clock cycles.
	localparam int PSC_RC_NS = 75;
	localparam int PSC_WC_NS = 75;
	localparam int PSC_WP_NS = 50;
	localparam int PSC_OE_NS = 25;
	localparam int PSC_OD_NS = 20;
	localparam int PSC_PC_NS = 30;
	localparam int PSC_DS_NS = 30;
	localparam int PSC_MAXCYC_US = 10;
	localparam int PSC_HOLD_US = 30;
	localparam int PSC_DPD_MS = 10;
	localparam int PSC_CH_US = 300;
	// Least times round up.
	localparam int PSC_RC_CYC = (PSC_RC_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
	localparam int PSC_WC_CYC = (PSC_WC_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
	localparam int PSC_WP_CYC = (PSC_WP_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
	localparam int PSC_PC_CYC = (PSC_PC_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
	localparam int PSC_OD_CYC = (PSC_OD_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
	localparam int PSC_DS_CYC = (PSC_DS_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
	// Microsecond and millisecond times round down.
	localparam int PSC_MAXCYC_CYC = PSC_MAXCYC_US * 1000 / PSC_CLK_NS;
	localparam int PSC_HOLD_CYC = PSC_HOLD_US * 1000 / PSC_CLK_NS;
	localparam int PSC_DPD_CYC = PSC_DPD_MS * 1000000 / PSC_CLK_NS;
	localparam int PSC_CH_CYC = PSC_CH_US * 1000 / PSC_CLK_NS;
	localparam int PSC_CNT_W = 24;

	typedef struct packed {
		logic chip_enable_n;
		logic power_down_select;
		logic output_enable_n;
		logic write_enable_n;
		logic lower_byte_sel_n;
		logic upper_byte_sel_n;
	} psc_ctl_t;

	localparam psc_ctl_t PSC_CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

	typedef struct packed {
		logic wr;
		logic [PSC_PAGE_BITS-1:0] len_m1;
		logic [1:0] byte_en;
		logic [PSC_AW-1:0] addr;
		logic [PSC_DW-1:0] wdata;
	} psc_req_t;

	typedef enum logic [3:0] {
		PSC_S_POWERUP = 4'h0,
		PSC_S_IDLE = 4'h1,
		PSC_S_RD = 4'h2,
		PSC_S_RD_PAGE = 4'h3,
		PSC_S_RD_END = 4'h4,
		PSC_S_WR_SETUP = 4'h5,
		PSC_S_WR_PULSE = 4'h6,
		PSC_S_WR_END = 4'h7,
		PSC_S_DPD = 4'h8,
		PSC_S_DPD_EXIT = 4'h9
	} psc_state_t;
endpackage : psc_pkg

// [psc_sync.sv]
`timescale 1ns/1ps
module psc_sync (
	input wire logic i_clk, // System clock.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic [psc_pkg::PSC_DW-1:0] i_async, // Pin level from outside.
	output logic [psc_pkg::PSC_DW-1:0] o_sync // Agreed level.
);
	import psc_pkg::*;

	logic [PSC_DW-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d, o_d;

	always_comb begin
		s1_d = i_async;
		s2_d = s1_q;
		s3_d = s2_q;
		o_d = o_sync;
		for (int i = 0; i < PSC_DW; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				o_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			o_sync <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			o_sync <= o_d;
		end
	end
endmodule : psc_sync

// [psc_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// [RQ1] Writes keep output_enable_n high so the memory never drives the data pins.
// [RQ2] Write enable falls before or with chip enable and byte selects.
// [RQ3] Chip enable and byte selects rise with write enable, never later.
// [RQ4] Controller data drivers are off whenever the memory may drive.
// [RQ5] Deep power-down loses data; a valid flag drops until software rewrites.
// [RQ6] Read cycles are never shorter than the minimum read cycle time.
// [RQ7] Write cycles are full length with a full minimum write pulse.
// [RQ8] power_down_select stays high 30 us after reset before any access.
// [RQ9] Page reads return up to 8 words, changing only low address bits.
// [RQ10] Power-down is entered by power_down_select low with chip enable high.
// [RQ11] Byte selects gate lower and upper data lanes.
// [RQ12] Every access sequence ends well within 10 us.
module psc_ctrl #(
	parameter int P_HOLD_CYC = psc_pkg::PSC_HOLD_CYC, // Power-on hold in cycles.
	parameter int P_DPD_CYC = psc_pkg::PSC_DPD_CYC, // Power-down pulse in cycles.
	parameter int P_CH_CYC = psc_pkg::PSC_CH_CYC // Power-down exit hold in cycles.
) (
	input wire logic i_clk, // System clock, 100 MHz.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic i_req_valid, // Access request.
	input wire psc_pkg::psc_req_t i_req, // Access request fields.
	input wire logic i_dpd_req, // Request deep power-down, pulse.
	input wire logic [psc_pkg::PSC_DW-1:0] i_mem_dq, // Data pins from memory.
	output logic o_req_ready, // Request accepted this cycle.
	output logic o_rdata_valid, // Read word valid, pulse.
	output logic [psc_pkg::PSC_DW-1:0] o_rdata, // Read word.
	output logic o_done, // Access finished, pulse.
	output logic o_busy, // Not idle.
	output logic o_data_valid, // Array contents valid.
	output psc_pkg::psc_ctl_t o_mem_ctl, // Memory control pins.
	output logic [psc_pkg::PSC_AW-1:0] o_mem_addr, // Memory address pins.
	output logic [psc_pkg::PSC_DW-1:0] o_mem_dq, // Data to memory.
	output logic [psc_pkg::PSC_DW-1:0] o_mem_dq_oe // Data drive enable, high drives.
);
	import psc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	psc_state_t st_q, st_d;
	logic [PSC_CNT_W-1:0] cnt_q, cnt_d;
	logic [PSC_PAGE_BITS-1:0] left_q, left_d;
	logic [PSC_DW-1:0] dq_sync;
	logic ready_q, ready_d, rv_q, rv_d, done_q, done_d, busy_q, busy_d, valid_q, valid_d;
	logic [PSC_DW-1:0] rdata_q, rdata_d, dq_q, dq_d, oe_q, oe_d;
	psc_ctl_t ctl_q, ctl_d;
	logic [PSC_AW-1:0] addr_q, addr_d;
	logic [1:0] be_q, be_d;

	// Read data arrive asynchronously; the settle time of the synchroniser is
	// covered by waiting the read cycle time, or the page cycle time for page words, plus slack before sampling.
	psc_sync u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_mem_dq),
		.o_sync(dq_sync)
	);

	localparam logic [PSC_CNT_W-1:0] RD_WAIT = PSC_CNT_W'(PSC_RC_CYC + 3);
	localparam logic [PSC_CNT_W-1:0] PG_WAIT = PSC_CNT_W'(PSC_PC_CYC + 3);
	localparam logic [PSC_CNT_W-1:0] WP_WAIT = PSC_CNT_W'(PSC_WP_CYC);
	localparam logic [PSC_CNT_W-1:0] WE_WAIT = PSC_CNT_W'(PSC_WC_CYC - PSC_WP_CYC);
	localparam logic [PSC_CNT_W-1:0] OD_WAIT = PSC_CNT_W'(PSC_OD_CYC + 1);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		left_d = left_q;
		ready_d = 1'b0;
		rv_d = 1'b0;
		done_d = 1'b0;
		rdata_d = rdata_q;
		valid_d = valid_q;
		ctl_d = ctl_q;
		addr_d = addr_q;
		be_d = be_q;
		dq_d = dq_q;
		oe_d = oe_q;
		if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
		unique case (st_q)
			PSC_S_POWERUP: begin
				ctl_d = PSC_CTL_IDLE; // RQ8
				if (cnt_q == '0) begin
					st_d = PSC_S_IDLE; // RQ8
				end
			end
			PSC_S_IDLE: begin
				ctl_d = PSC_CTL_IDLE;
				oe_d = '0;
				if (i_dpd_req) begin
					ctl_d.power_down_select = 1'b0; // RQ10
					valid_d = 1'b0; // RQ5
					cnt_d = PSC_CNT_W'(P_DPD_CYC);
					st_d = PSC_S_DPD;
				end else if (i_req_valid) begin
					ready_d = 1'b1;
					addr_d = i_req.addr;
					be_d = i_req.byte_en;
					left_d = i_req.len_m1;
					if (i_req.wr) begin
						// Write enable falls first; chip enable and lanes follow.
						ctl_d.write_enable_n = 1'b0; // RQ2
						ctl_d.output_enable_n = 1'b1; // RQ1
						dq_d = i_req.wdata;
						cnt_d = '0;
						st_d = PSC_S_WR_SETUP;
					end else begin
						ctl_d.chip_enable_n = 1'b0;
						ctl_d.output_enable_n = 1'b0; // RQ4
						ctl_d.lower_byte_sel_n = ~i_req.byte_en[0]; // RQ11
						ctl_d.upper_byte_sel_n = ~i_req.byte_en[1]; // RQ11
						cnt_d = RD_WAIT; // RQ6
						st_d = PSC_S_RD;
					end
				end
			end
			PSC_S_RD, PSC_S_RD_PAGE: begin
				if (cnt_q == '0) begin
					// Unselected lanes float on the pins, so they are forced to zero here.
					rdata_d = dq_sync;
					if (!be_q[0]) rdata_d[7:0] = '0; // RQ11
					if (!be_q[1]) rdata_d[15:8] = '0; // RQ11
					rv_d = 1'b1;
					if (left_q != '0) begin
						left_d = left_q - 1'b1;
						// Only the in-page bits move while enables stay low.
						addr_d[PSC_PAGE_BITS-1:0] = addr_q[PSC_PAGE_BITS-1:0] + 1'b1; // RQ9
						cnt_d = PG_WAIT; // RQ9
						st_d = PSC_S_RD_PAGE;
					end else begin
						ctl_d = PSC_CTL_IDLE;
						cnt_d = OD_WAIT; // RQ4
						st_d = PSC_S_RD_END;
					end
				end
			end
			PSC_S_RD_END: begin
				if (cnt_q == '0) begin
					done_d = 1'b1;
					st_d = PSC_S_IDLE; // RQ12
				end
			end
			PSC_S_WR_SETUP: begin
				ctl_d.chip_enable_n = 1'b0; // RQ2
				ctl_d.lower_byte_sel_n = ~be_q[0]; // RQ11
				ctl_d.upper_byte_sel_n = ~be_q[1]; // RQ11
				oe_d = {{8{be_q[1]}}, {8{be_q[0]}}}; // RQ4
				cnt_d = WP_WAIT; // RQ7
				st_d = PSC_S_WR_PULSE;
			end
			PSC_S_WR_PULSE: begin
				if (cnt_q == '0) begin
					// All strobes rise together, ending the write on the same edge.
					ctl_d = PSC_CTL_IDLE; // RQ3
					cnt_d = WE_WAIT; // RQ7
					st_d = PSC_S_WR_END;
				end
			end
			PSC_S_WR_END: begin
				oe_d = '0;
				if (cnt_q == '0) begin
					done_d = 1'b1;
					st_d = PSC_S_IDLE;
				end
			end
			PSC_S_DPD: begin
				ctl_d.chip_enable_n = 1'b1; // RQ10
				ctl_d.power_down_select = 1'b0; // RQ10
				if (cnt_q == '0 && !i_dpd_req) begin
					ctl_d.power_down_select = 1'b1;
					cnt_d = PSC_CNT_W'(P_CH_CYC);
					st_d = PSC_S_DPD_EXIT;
				end
			end
			PSC_S_DPD_EXIT: begin
				if (cnt_q == '0) begin
					st_d = PSC_S_IDLE;
				end
			end
			default: begin
				st_d = PSC_S_IDLE;
				ctl_d = PSC_CTL_IDLE;
				oe_d = '0;
			end
		endcase
		if (st_q == PSC_S_IDLE && i_req_valid && !i_dpd_req && i_req.wr) begin
			valid_d = 1'b1; // RQ5
		end
		busy_d = (st_d != PSC_S_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= PSC_S_POWERUP;
			cnt_q <= PSC_CNT_W'(P_HOLD_CYC);
			left_q <= '0;
			ready_q <= 1'b0;
			rv_q <= 1'b0;
			done_q <= 1'b0;
			busy_q <= 1'b1;
			valid_q <= 1'b0;
			rdata_q <= '0;
			ctl_q <= PSC_CTL_IDLE;
			addr_q <= '0;
			be_q <= '0;
			dq_q <= '0;
			oe_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			left_q <= left_d;
			ready_q <= ready_d;
			rv_q <= rv_d;
			done_q <= done_d;
			busy_q <= busy_d;
			valid_q <= valid_d;
			rdata_q <= rdata_d;
			ctl_q <= ctl_d;
			addr_q <= addr_d;
			be_q <= be_d;
			dq_q <= dq_d;
			oe_q <= oe_d;
		end
	end

	assign o_req_ready = ready_q;
	assign o_rdata_valid = rv_q;
	assign o_rdata = rdata_q;
	assign o_done = done_q;
	assign o_busy = busy_q;
	assign o_data_valid = valid_q;
	assign o_mem_ctl = ctl_q;
	assign o_mem_addr = addr_q;
	assign o_mem_dq = dq_q;
	assign o_mem_dq_oe = oe_q;
endmodule : psc_ctrl

// [psc_ctrl_sva.sv]
`timescale 1ns/1ps
module psc_ctrl_sva #(
	parameter int P_HOLD_CYC = psc_pkg::PSC_HOLD_CYC // Power-on hold in cycles.
) (
	input wire logic i_clk, // Clock.
	input wire logic i_rst_n, // Reset, active low.
	input wire logic o_data_valid, // Array valid.
	input wire psc_pkg::psc_ctl_t o_mem_ctl, // Control pins.
	input wire logic [psc_pkg::PSC_AW-1:0] o_mem_addr, // Address pins.
	input wire logic [psc_pkg::PSC_DW-1:0] o_mem_dq_oe // Data enables.
);
	import psc_pkg::*;
	psc_ctl_t c;
	logic [15:0] hold_q;
	logic [15:0] hold_d;
	logic [PSC_CNT_W-1:0] sel_q;
	logic [PSC_CNT_W-1:0] sel_d;
	assign c = o_mem_ctl;
	// Saturating age since reset, so the power-on window can be judged.
	// Cycles spent selected without a break; a long run would starve the internal refresh.
	always_comb begin
		hold_d = (hold_q == 16'hFFFF) ? hold_q : hold_q + 16'h0001;
		sel_d = c.chip_enable_n ? '0 : sel_q + 1'b1;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_q <= 16'h0000;
			sel_q <= '0;
		end else begin
			hold_q <= hold_d;
			sel_q <= sel_d;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_we_lead;
		$fell(c.write_enable_n) && c.chip_enable_n && c.lower_byte_sel_n && c.upper_byte_sel_n;
	endsequence
	sequence s_pulse;
		!c.chip_enable_n && !c.write_enable_n;
	endsequence
	property p_wr_oe; !c.write_enable_n |-> c.output_enable_n; endproperty
	a_wr_oe: assert property (p_wr_oe) else $error("read enable low in write");
	property p_we_lead; $fell(c.write_enable_n) |-> s_we_lead; endproperty
	a_we_lead: assert property (p_we_lead) else $error("strobe fell before write");
	property p_we_rise;
		$rose(c.write_enable_n) |-> c.chip_enable_n && c.lower_byte_sel_n && c.upper_byte_sel_n;
	endproperty
	a_we_rise: assert property (p_we_rise) else $error("strobe held after write");
	property p_dq_oe; (|o_mem_dq_oe) |-> c.output_enable_n; endproperty
	a_dq_oe: assert property (p_dq_oe) else $error("data drive while memory may drive");
	property p_lost; !c.power_down_select |-> !o_data_valid; endproperty
	a_lost: assert property (p_lost) else $error("data valid in power-down");
	property p_rd_len; $fell(c.output_enable_n) |-> (!c.output_enable_n && !c.chip_enable_n) [*8]; endproperty
	a_rd_len: assert property (p_rd_len) else $error("read cycle short");
	property p_wr_len; s_we_lead |=> s_pulse [*5]; endproperty
	a_wr_len: assert property (p_wr_len) else $error("write pulse short");
	property p_hold; hold_q < P_HOLD_CYC |-> c.power_down_select && c.chip_enable_n; endproperty
	a_hold: assert property (p_hold) else $error("access in power-on hold");
	property p_page;
		!c.chip_enable_n && !c.output_enable_n && $past(!c.chip_enable_n && !c.output_enable_n)
			|-> $stable(o_mem_addr[PSC_AW-1:PSC_PAGE_BITS]);
	endproperty
	a_page: assert property (p_page) else $error("page read left page");
	property p_dpd; $fell(c.power_down_select) |-> c.chip_enable_n; endproperty
	a_dpd: assert property (p_dpd) else $error("power-down while selected");
	property p_short; sel_q < PSC_MAXCYC_CYC; endproperty
	a_short: assert property (p_short) else $error("memory held selected too long");
endmodule : psc_ctrl_sva

// [psc_mem_model.sv]
`timescale 1ns/1ps
module psc_mem_model (
	input wire psc_pkg::psc_ctl_t i_ctl, // Control pins.
	input wire logic [psc_pkg::PSC_AW-1:0] i_addr, // Address pins.
	input wire logic [psc_pkg::PSC_DW-1:0] i_dq, // Resolved data wire.
	input wire logic [psc_pkg::PSC_DW-1:0] i_host_oe, // Controller enables.
	output logic [psc_pkg::PSC_DW-1:0] o_dq, // Memory data.
	output logic [psc_pkg::PSC_DW-1:0] o_dq_oe, // Memory enables.
	output logic o_clash // Both sides drove.
);
	import psc_pkg::*;
	logic [PSC_DW-1:0] mem [int];
	logic [PSC_DW-1:0] lanes;
	logic rd;
	initial o_clash = 1'b0;
	assign lanes = {{8{!i_ctl.upper_byte_sel_n}}, {8{!i_ctl.lower_byte_sel_n}}};
	// Any low write strobe keeps the outputs off, whatever the order of edges.
	assign rd = !i_ctl.chip_enable_n && i_ctl.power_down_select
		&& !i_ctl.output_enable_n && i_ctl.write_enable_n;
	assign o_dq_oe = rd ? lanes : '0;
	always @(i_addr or i_ctl) begin
		o_dq = mem.exists(i_addr) ? mem[i_addr] : 16'hC3C3;
	end
	always @(i_dq or i_host_oe or i_ctl or i_addr) begin
		if (!i_ctl.chip_enable_n && !i_ctl.write_enable_n && i_ctl.power_down_select) begin
			mem[i_addr] = ((mem.exists(i_addr) ? mem[i_addr] : '0) & ~(i_host_oe & lanes))
				| (i_dq & i_host_oe & lanes);
		end
	end
	always @(negedge i_ctl.power_down_select) begin
		mem.delete();
	end
	always @(o_dq_oe or i_host_oe) begin
		if ((o_dq_oe & i_host_oe) != '0) begin
			o_clash = 1'b1;
		end
	end
endmodule : psc_mem_model

// [test_psram_async_access_rules.sv]
`timescale 1ns/1ps
module test_psram_async_access_rules;
	import psc_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic req_valid = 1'b0;
	psc_req_t req = '0;
	logic dpd_req = 1'b0;
	logic [15:0] dq_w, mem_dq, mem_oe, host_dq, host_oe, rdata;
	psc_ctl_t ctl;
	logic [21:0] addr;
	logic ready, rvalid, done, busy, dvalid, clash;
	logic [15:0] exp_mem [int];
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	always #5 i_clk = ~i_clk;
	// Released lines toggle so a stale level never passes for data.
	assign dq_w = (host_oe & host_dq) | (mem_oe & mem_dq) | (~(host_oe | mem_oe) & (16'hA5A5 ^ {16{i_clk}}));
	psc_ctrl #(.P_HOLD_CYC(50), .P_DPD_CYC(20), .P_CH_CYC(20)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_req_valid(req_valid), .i_req(req), .i_dpd_req(dpd_req), .i_mem_dq(dq_w), .o_req_ready(ready),
		.o_rdata_valid(rvalid), .o_rdata(rdata), .o_done(done), .o_busy(busy), .o_data_valid(dvalid),
		.o_mem_ctl(ctl), .o_mem_addr(addr), .o_mem_dq(host_dq), .o_mem_dq_oe(host_oe));
	psc_mem_model mem_u (.i_ctl(ctl), .i_addr(addr), .i_dq(dq_w), .i_host_oe(host_oe), .o_dq(mem_dq),
		.o_dq_oe(mem_oe), .o_clash(clash));
	////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic access(input logic wr, input logic [2:0] lm1, input logic [1:0] be, input logic [21:0] a,
		input logic [15:0] wd);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}};
		@(posedge i_clk);
		req_valid <= 1'b1;
		req <= '{wr, lm1, be, a, wd};
		do @(negedge i_clk); while (ready !== 1'b1);
		@(posedge i_clk);
		req_valid <= 1'b0;
		if (wr) begin
			exp_mem[int'(a)] = (exp_mem[int'(a)] & ~m) | (wd & m);
		end else begin
			for (int k = 0; k <= int'(lm1); k++) begin
				do @(negedge i_clk); while (rvalid !== 1'b1);
				chk(rdata, exp_mem[int'(a) + k] & m);
			end
		end
		do @(negedge i_clk); while (done !== 1'b1);
	endtask : access
	task t_word;
		access(1'b1, 3'h0, 2'h3, 22'h000100, 16'hA55A);
		access(1'b1, 3'h0, 2'h1, 22'h000100, 16'h1234);
		access(1'b0, 3'h0, 2'h3, 22'h000100, 16'h0000);
		access(1'b0, 3'h0, 2'h2, 22'h000100, 16'h0000);
		chk(dvalid, 1'b1);
		$display("word and lane test done");
	endtask : t_word
	task t_page;
		for (int k = 0; k < 8; k++) begin
			access(1'b1, 3'h0, 2'h3, 22'h000200 + 22'(k), 16'h0F00 + 16'(k));
		end
		access(1'b0, 3'h7, 2'h3, 22'h000200, 16'h0000);
		$display("page test done");
	endtask : t_page
	task t_dpd;
		@(posedge i_clk);
		dpd_req <= 1'b1;
		do @(negedge i_clk); while (ctl.power_down_select !== 1'b0);
		chk(ctl.chip_enable_n, 1'b1);
		@(posedge i_clk);
		dpd_req <= 1'b0;
		do @(negedge i_clk); while (busy !== 1'b0);
		chk(dvalid, 1'b0);
		access(1'b1, 3'h0, 2'h3, 22'h000300, 16'h5AA5);
		access(1'b0, 3'h0, 2'h3, 22'h000300, 16'h0000);
		$display("power-down test done");
	endtask : t_dpd
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(negedge i_clk);
		chk(ctl.power_down_select, 1'b1);
		chk(dvalid, 1'b0);
		t_word();
		t_page();
		t_dpd();
		chk(clash, 1'b0);
		print_verdict();
	end
endmodule : test_psram_async_access_rules
bind psc_ctrl psc_ctrl_sva #(.P_HOLD_CYC(P_HOLD_CYC)) sva_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.o_data_valid(o_data_valid), .o_mem_ctl(o_mem_ctl), .o_mem_addr(o_mem_addr), .o_mem_dq_oe(o_mem_dq_oe));
